// >>> core/adct_pkg.sv
// Package for the converter timing control: field codes, counts, carriers.
// Assumes a single 20 MHz clock and synchronous active-high reset.
package adct_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int ADCT_CONV_BC = 40;
  localparam int ADCT_LOAD_CLKS = 2;
  localparam logic [9:0] ADCT_CODE_MIN = 10'h000;
  localparam logic [9:0] ADCT_CODE_MAX = 10'h3ff;
  localparam logic [15:0] ADCT_RESULT_RST = 16'h0000;
  localparam logic [1:0] ADCT_DIV_RST = 2'h0;
  localparam logic [1:0] ADCT_STC_RST = 2'h0;
  localparam int ADCT_DIV_W = 4;
  localparam int ADCT_BC_W = 7;

  typedef enum logic [1:0] {
    ADCT_IDLE = 2'b00,
    ADCT_SAMPLE = 2'b01,
    ADCT_CONVERT = 2'b11,
    ADCT_LOAD = 2'b10
  } adct_state_t;

  // Analog front end sample: comparator flags plus the raw code
  typedef struct packed {
    logic below_ref;
    logic above_ref;
    logic [9:0] code;
  } adct_ain_t;

  typedef struct packed {
    logic [1:0] basic_clock_divider_select;
    logic [1:0] sample_time_select;
  } adct_cfg_t;
endpackage

// >>> core/adct_bc_div.sv
// Basic clock divider: produces a one-cycle enable per basic clock period.
// Assumes the divider select is stable while a conversion runs.
`timescale 1ns/10ps
module adct_bc_div
  import adct_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [1:0] basic_clock_divider_select,
  // Enable out
  output logic bc_tick
);
  logic [ADCT_DIV_W-1:0] cnt_q;
  logic [ADCT_DIV_W-1:0] cnt_d;
  logic [ADCT_DIV_W-1:0] last;

  // Code to terminal count; code 10 is the slowest, not 11
  function automatic logic [ADCT_DIV_W-1:0] div_last(input logic [1:0] s);
    case (s)
      2'h0: div_last = 4'h3;
      2'h1: div_last = 4'h1;
      2'h2: div_last = 4'hf;
      default: div_last = 4'h7;
    endcase
  endfunction

  assign last = div_last(basic_clock_divider_select);
  assign bc_tick = run && (cnt_q == last);
  assign cnt_d = (!run || bc_tick) ? 4'h0 : cnt_q + 4'h1;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_d;
  end

  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    bc_tick && $stable(basic_clock_divider_select) |-> ##1 !bc_tick)
    else $error("basic clock tick repeated");
endmodule

// >>> core/adct_ctrl.sv
// Conversion timing control: sample, result determination, result load.
// Assumes the analog front end presents a stable code and range flags.
`timescale 1ns/10ps
module adct_ctrl
  import adct_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration and start
  input wire adct_cfg_t cfg,
  input wire logic start,
  // Analog front end
  input wire adct_ain_t ain,
  output logic sample_en,
  // Status and result
  output logic busy,
  output logic done,
  output logic [15:0] result
);
  adct_state_t state_q;
  adct_state_t state_d;
  adct_cfg_t cfg_q;
  adct_ain_t held_q;
  logic [ADCT_BC_W-1:0] bc_q;
  logic [ADCT_BC_W-1:0] bc_d;
  logic [15:0] result_q;
  logic done_q;
  logic load_q;
  logic bc_tick;
  logic run;
  logic [ADCT_BC_W-1:0] samp_last;
  logic samp_end;
  logic conv_end;
  logic [9:0] sat_code;
  logic [11:0] bc_per;
  logic [11:0] samp_cyc;

  function automatic logic [ADCT_BC_W-1:0] samp_len(input logic [1:0] s);
    case (s)
      2'h0: samp_len = 7'd7;
      2'h1: samp_len = 7'd15;
      2'h2: samp_len = 7'd31;
      default: samp_len = 7'd63;
    endcase
  endfunction

  // Basic clock period in CPU clocks, for the length checks only
  function automatic logic [4:0] div_fac(input logic [1:0] s);
    case (s)
      2'h0: div_fac = 5'd4;
      2'h1: div_fac = 5'd2;
      2'h2: div_fac = 5'd16;
      default: div_fac = 5'd8;
    endcase
  endfunction

  // Configuration frozen at start so the length stays fixed
  assign run = (state_q == ADCT_SAMPLE) || (state_q == ADCT_CONVERT);
  assign samp_last = samp_len(cfg_q.sample_time_select);
  assign samp_end = (state_q == ADCT_SAMPLE) && bc_tick && (bc_q == samp_last);
  assign conv_end = (state_q == ADCT_CONVERT) && bc_tick &&
    (bc_q == 7'(ADCT_CONV_BC - 1));
  assign sample_en = (state_q == ADCT_SAMPLE);
  assign busy = (state_q != ADCT_IDLE);
  assign done = done_q;
  assign result = result_q;
  assign sat_code = held_q.below_ref ? ADCT_CODE_MIN :
    held_q.above_ref ? ADCT_CODE_MAX : held_q.code;

  adct_bc_div u_div (
    .clk(clk),
    .rst(rst),
    .run(run),
    .basic_clock_divider_select(cfg_q.basic_clock_divider_select),
    .bc_tick(bc_tick)
  );

  always_comb
  begin
    state_d = state_q;
    bc_d = bc_q;
    case (state_q)
      ADCT_IDLE:
        if (start)
        begin
          state_d = ADCT_SAMPLE;
          bc_d = 7'd0;
        end
      ADCT_SAMPLE:
        if (samp_end)
        begin
          state_d = ADCT_CONVERT;
          bc_d = 7'd0;
        end
        else if (bc_tick)
          bc_d = bc_q + 7'd1;
      ADCT_CONVERT:
        if (conv_end)
          state_d = ADCT_LOAD;
        else if (bc_tick)
          bc_d = bc_q + 7'd1;
      ADCT_LOAD:
        // Two CPU clocks: this state plus the load edge
        state_d = load_q ? ADCT_IDLE : ADCT_LOAD;
      default:
        state_d = ADCT_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ADCT_IDLE;
      bc_q <= 7'd0;
      cfg_q <= '{ADCT_DIV_RST, ADCT_STC_RST};
      held_q <= '0;
      result_q <= ADCT_RESULT_RST;
      done_q <= 1'b0;
      load_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      bc_q <= bc_d;
      if (state_q == ADCT_IDLE && start)
        cfg_q <= cfg;
      if (state_q == ADCT_SAMPLE)
        held_q <= ain;
      load_q <= (state_q == ADCT_LOAD) && !load_q;
      if (state_q == ADCT_LOAD && load_q)
        result_q <= {6'h00, sat_code};
      done_q <= (state_q == ADCT_LOAD) && load_q;
    end
  end

  // Start to done: helper counter of CPU cycles
  logic [11:0] len_q;
  logic [11:0] len_exp;
  always_ff @(posedge clk)
  begin
    if (rst || (state_q == ADCT_IDLE))
      len_q <= 12'd0;
    else
      len_q <= len_q + 12'd1;
  end
  assign bc_per = 12'(div_fac(cfg_q.basic_clock_divider_select));
  assign samp_cyc = (12'(samp_last) + 12'd1) * bc_per - 12'd1;
  assign len_exp = (12'(samp_last) + 12'd1 + 12'(ADCT_CONV_BC)) * bc_per +
    12'(ADCT_LOAD_CLKS);

  // Convert phase counted apart from bc_q, so a wrong divider shows up
  logic [11:0] cvt_q;
  logic [11:0] cvt_exp;
  always_ff @(posedge clk)
  begin
    if (rst || (state_q != ADCT_CONVERT))
      cvt_q <= 12'd0;
    else
      cvt_q <= cvt_q + 12'd1;
  end
  assign cvt_exp = 12'(ADCT_CONV_BC) * bc_per - 12'd1;

  a_conv_length: assert property (@(posedge clk) disable iff (rst)
    done_q |-> len_q == len_exp)
    else $error("conversion length wrong");
  a_phase_order: assert property (@(posedge clk) disable iff (rst)
    state_q == ADCT_SAMPLE |=> state_q inside {ADCT_SAMPLE, ADCT_CONVERT})
    else $error("sample phase left wrongly");
  a_load_after: assert property (@(posedge clk) disable iff (rst)
    state_q == ADCT_CONVERT && state_d == ADCT_LOAD |-> ##3 done_q)
    else $error("result not loaded after conversion");
  a_sat_low: assert property (@(posedge clk) disable iff (rst)
    done_q && held_q.below_ref |-> result_q == 16'h0000)
    else $error("low saturation wrong");
  a_sat_high: assert property (@(posedge clk) disable iff (rst)
    done_q && held_q.above_ref && !held_q.below_ref |-> result_q == 16'h03ff)
    else $error("high saturation wrong");
  a_hold_input: assert property (@(posedge clk) disable iff (rst)
    state_q inside {ADCT_CONVERT, ADCT_LOAD} |=> $stable(held_q))
    else $error("input changed after sample");
  a_result_width: assert property (@(posedge clk) disable iff (rst)
    result_q[15:10] == 6'h00)
    else $error("result upper bits set");
  a_sample_len: assert property (@(posedge clk) disable iff (rst)
    samp_end |-> len_q == samp_cyc)
    else $error("sample length wrong");
  a_result_still: assert property (@(posedge clk) disable iff (rst)
    !done_q |=> $stable(result_q) || done_q)
    else $error("result changed outside load");
  a_conv_span: assert property (@(posedge clk) disable iff (rst)
    conv_end |-> cvt_q == cvt_exp)
    else $error("convert phase length wrong");
  a_load_two: assert property (@(posedge clk) disable iff (rst)
    state_q == ADCT_LOAD && !load_q |=> state_q == ADCT_LOAD)
    else $error("load phase too short");
  a_cfg_frozen: assert property (@(posedge clk) disable iff (rst)
    busy |=> $stable(cfg_q))
    else $error("setting changed during conversion");
  a_done_pulse: assert property (@(posedge clk) disable iff (rst)
    done_q |=> !done_q)
    else $error("done longer than one cycle");
  a_hold_sample: assert property (@(posedge clk) disable iff (rst)
    state_q == ADCT_SAMPLE |=> held_q == $past(ain))
    else $error("input not taken while sampling");
  a_result_code: assert property (@(posedge clk) disable iff (rst)
    done_q && !held_q.below_ref && !held_q.above_ref |->
    result_q == {6'h00, held_q.code})
    else $error("in-range code not passed through");

  c_conv: cover property (@(posedge clk) done_q);
  c_refused: cover property (@(posedge clk) busy && start);
  c_low: cover property (@(posedge clk) done_q && held_q.below_ref);
  c_high: cover property (@(posedge clk) done_q && held_q.above_ref);
  c_slow: cover property (@(posedge clk)
    done_q && cfg_q.basic_clock_divider_select == 2'h2);
endmodule

// >>> testbench/adct_src.sv
// Analog source model for the conversion timing control.
// Assumes the level-valued input struct shares the control clock.
`timescale 1ns/10ps
module adct_src
  import adct_pkg::*;
(
  // Sample phase indicator
  sample_en,
  // Value to present while sampling
  val,
  // Input to the control block
  ain
);
  input wire logic sample_en;
  input wire adct_ain_t val;
  output adct_ain_t ain;
  // Input moves once sampling ends, so late changes must not leak in
  assign ain = sample_en ? val : ~val;
endmodule

// >>> testbench/adc_conversion_timing_control_test.sv
// Self-checking bench for the conversion timing control.
// Assumes a 20 MHz clock; drives inputs by non-blocking assignment.
`timescale 1ns/10ps
module adc_conversion_timing_control_test
  import adct_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  adct_cfg_t cfg = '0;
  adct_ain_t val = '0;
  adct_ain_t ain;
  logic sample_en;
  logic busy;
  logic done;
  logic [15:0] result;
  int n_errors = 0;
  int n_compared = 0;

  adct_ctrl DUT (.clk(clk), .rst(rst), .cfg(cfg), .start(start), .ain(ain),
    .sample_en(sample_en), .busy(busy), .done(done), .result(result));
  adct_src src (.sample_en(sample_en), .val(val), .ain(ain));

  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One conversion; counts cycles from the taking edge to done
  task automatic conv(input logic [3:0] c, input adct_ain_t v,
    input logic [15:0] exp_res);
    int n;
    int d;
    int s;
    int ns;
    d = (c[3:2] == 2'h0) ? 4 : (c[3:2] == 2'h1) ? 2 :
      (c[3:2] == 2'h2) ? 16 : 8;
    s = 8 << c[1:0];
    n = 0;
    ns = 0;
    @(posedge clk);
    cfg <= c;
    val <= v;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    do
    begin
      if (sample_en === 1'b1)
        ns++;
      @(posedge clk);
      // Refused mid-run: a second start and a new setting change nothing
      start <= (n == 4);
      cfg <= ~c;
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 3000);
    chk(16'(n), 16'((s + 40) * d + 2));
    chk(16'(ns), 16'(s * d));
    chk(result, exp_res);
    chk({15'h0, busy}, 16'h0);
    @(posedge clk);
    #1;
    chk({15'h0, done}, 16'h0);
  endtask

  // Every divider code but 01 and every sample code, with plain and out-of-range inputs
  task automatic sweep();
    adct_ain_t v;
    logic [15:0] e;
    for (int d = 0; d < 4; d++)
    begin
      // Divide-by-2 gives 10 MHz, beyond the allowed basic clock
      if (d == 1)
        continue;
      for (int s = 0; s < 4; s++)
      begin
        v.below_ref = (s == 1) || (s == 3);
        v.above_ref = (s >= 2);
        v.code = 10'h2a5 ^ 10'(d * 4 + s);
        e = v.below_ref ? 16'h0000 : v.above_ref ? 16'h03ff : {6'h00, v.code};
        conv({2'(d), 2'(s)}, v, e);
      end
    end
  endtask

  // Reset in mid-run: outputs fall back to their reset values
  task automatic abort();
    @(posedge clk);
    cfg <= 4'h0;
    val <= '0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({14'h0, busy, done}, 16'h0000);
    chk({15'h0, sample_en}, 16'h0000);
    chk(result, 16'h0000);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(result, 16'h0000);
    chk({14'h0, busy, done}, 16'h0000);
    chk({15'h0, sample_en}, 16'h0000);
    sweep();
    conv(4'h0, 12'h155, 16'h0155);
    abort();
    conv(4'hc, 12'h2aa, 16'h02aa);
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule
